// >>> src/tfp_ff_cell.sv
// One timer output flip-flop: software force or toggle on its source event
`timescale 1ns/1ns
module tfp_ff_cell
    import tfp_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic src_evt,
    input  wire logic wr_en,
    input  wire logic wr_val,
    output logic      q
);

    // A software force takes priority over a coinciding source event
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= RST_FF_OUT;
        end else if (wr_en) begin
            q <= wr_val;
        end else if (src_evt) begin
            q <= ~q;
        end
    end

endmodule : tfp_ff_cell

// >>> src/tfp_ff_ctrl.sv
// Timer output flip-flop source select, write protect and data register
//
// Functional notes
// - Flip-flops 15..11 take timer channels 4..0 on a 0 selector and bus 0,0,3,2,1 on a 1.
// - Flip-flops 10 and 9 take their channel on 0x, event bus 0 on 10 and bus 1 on 11.
// - Flip-flop 8 takes its channel on 00, then bus 0, 1 and 2 on codes 01, 10 and 11.
// - Flip-flop 7 takes bus 0 on a 1 and flip-flop 6 bus 1 on a 1, else their channel.
// - Flip-flops 19..17 take channels 8..6 on 0x, event bus 0 on 10 and bus 1 on 11.
// - Flip-flop 16 takes channel 5 on 00, then bus 0, 1 and 3 on codes 01, 10 and 11.
// - A flip-flop is driven only by event bus lines or its own timer channel output.
// - Each lock bit guards one flip-flop; 1 blocks software writes, 0 allows them.
// - A blocked write to the data register does not change that flip-flop; a coinciding source event still toggles it.
// - After reset the lock and low select registers read zero and all writes pass.
// - The three top unused bits of the low select register always read as zero.
// - A permitted data write forces the output; otherwise it follows its source.
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ns
module tfp_ff_ctrl
    import tfp_pkg::*;
#(
    parameter int N_FF = 20
)
(
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic [tfp_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic      [31:0]               avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic [N_FF-1:0]           ch_evt,
    input  wire logic [tfp_pkg::EVT_W-1:0] evt_bus,
    output logic      [N_FF-1:0]           ff_out
);
    import tfp_pkg::*;

    logic [15:0]     ff_source_select_lo;
    logic [7:0]      ff_source_select_hi;
    logic [15:0]     ff_write_protect_lo;
    logic [N_FF-1:0] sel_evt;
    logic [N_FF-1:0] wr_en;
    logic [15:0]     wmask16;
    logic [15:0]     next_rdata;
    logic            bus_req;
    logic            bus_acc;
    logic            wr_acc;
    logic            wr_data;
    logic            after_rst;

    // A request completes at the edge where waitrequest is seen low
    assign bus_req = avs_read | avs_write;
    assign bus_acc = bus_req & ~avs_waitrequest;
    assign wr_acc  = avs_write & ~avs_waitrequest;
    assign wr_data = wr_acc & (avs_address == IDX_OUT_DATA);
    assign wmask16 = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Picks the source event of flip-flop n from its selector field
    function automatic logic pick_src(input int n, input logic [15:0] lo,
                                      input logic [7:0] hi, input logic [N_FF-1:0] ch,
                                      input logic [EVT_W-1:0] bus);
        logic [1:0] code;
        logic       res;
        code = 2'b00;
        res  = ch[n];
        unique case (n)
            15: res = lo[POS_SEL_FIFTEEN]   ? bus[0] : ch[n];
            14: res = lo[POS_SEL_FOURTEEN]  ? bus[0] : ch[n];
            13: res = lo[POS_SEL_THIRTEEN]  ? bus[3] : ch[n];
            12: res = lo[POS_SEL_TWELVE]    ? bus[2] : ch[n];
            11: res = lo[POS_SEL_ELEVEN]    ? bus[1] : ch[n];
            10, 9: begin
                code = (n == 10) ? lo[POS_SEL_TEN+:2] : lo[POS_SEL_NINE+:2];
                res  = code[1] ? bus[code[0]] : ch[n];
            end
            8: begin
                code = lo[POS_SEL_EIGHT+:2];
                res  = (code == 2'h0) ? ch[n] : bus[code - 2'h1];
            end
            7: res = lo[POS_SEL_SEVEN] ? bus[0] : ch[n];
            6: res = lo[POS_SEL_SIX]   ? bus[1] : ch[n];
            19, 18, 17: begin
                code = (n == 19) ? hi[POS_SEL_NINETEEN+:2] :
                       (n == 18) ? hi[POS_SEL_EIGHTEEN+:2] : hi[POS_SEL_SEVENTEEN+:2];
                res  = code[1] ? bus[code[0]] : ch[n];
            end
            16: begin
                code = hi[POS_SEL_SIXTEEN+:2];
                res  = (code == 2'h0) ? ch[n] :
                       (code == 2'h3) ? bus[3] : bus[code[1]];
            end
            default: res = ch[n];
        endcase
        return res;
    endfunction : pick_src

    // Per flip-flop source mux, write gate and storage cell
    generate
        for (genvar k = 0; k < N_FF; k++) begin : g_ff
            // Only bus lines or the own channel can reach the cell
            assign sel_evt[k] = pick_src(k, ff_source_select_lo,
                                         ff_source_select_hi, ch_evt, evt_bus);
            if (k < NUM_LOCK) begin : g_lockable
                // Lock bit k guards flip-flop k; blocked writes never reach the cell
                assign wr_en[k] = wr_data & wmask16[k] & ~ff_write_protect_lo[k];
            end else begin : g_unlocked
                // No data bit is mapped for these flip-flops in this block
                assign wr_en[k] = 1'b0;
            end
            tfp_ff_cell u_cell (
                .clk     (clk),
                .nrst    (nrst),
                .src_evt (sel_evt[k]),
                .wr_en   (wr_en[k]),
                .wr_val  (avs_writedata[k % 16]),
                .q       (ff_out[k])
            );
        end
    endgenerate

    // Low source select; unused top bits are never stored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ff_source_select_lo <= RST_SRC_SEL_LO;
        end else if (wr_acc && avs_address == IDX_SRC_SEL_LO) begin
            ff_source_select_lo <= ((ff_source_select_lo & ~wmask16) |
                                    (avs_writedata[15:0] & wmask16)) & SRC_SEL_LO_WMASK;
        end
    end

    // High source select, byte wide in lane 0
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ff_source_select_hi <= RST_SRC_SEL_HI;
        end else if (wr_acc && avs_address == IDX_SRC_SEL_HI && avs_byteenable[0]) begin
            ff_source_select_hi <= avs_writedata[7:0];
        end
    end

    // Lock register; a selection change simply re-steers the mux next cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ff_write_protect_lo <= RST_WR_LOCK_LO;
        end else if (wr_acc && avs_address == IDX_WR_LOCK_LO) begin
            ff_write_protect_lo <= (ff_write_protect_lo & ~wmask16) |
                                   (avs_writedata[15:0] & wmask16);
        end
    end

    // Read mux; unmapped indices read zero
    always_comb begin
        next_rdata = 16'h0000;
        unique case (avs_address)
            IDX_SRC_SEL_LO: next_rdata = ff_source_select_lo;
            IDX_SRC_SEL_HI: next_rdata = {8'h00, ff_source_select_hi};
            IDX_WR_LOCK_LO: next_rdata = ff_write_protect_lo;
            IDX_OUT_DATA:   next_rdata = ff_out[15:0];
            default:        next_rdata = 16'h0000;
        endcase
    end

    // One wait state per access: waitrequest drops for a single cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_waitrequest <= 1'b1;
        end else if (bus_req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // Read data captured together with the waitrequest drop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= {16'h0000, next_rdata};
        end
    end

    // Marks the first clock after reset release, for checking only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            after_rst <= 1'b1;
        end else begin
            after_rst <= 1'b0;
        end
    end

    // Waitrequest low never lasts more than one cycle
    chk_wait_single: assert property (@(posedge clk) disable iff (!nrst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    // A pending request is answered on the next cycle
    chk_answer_bound: assert property (@(posedge clk) disable iff (!nrst)
        (bus_req && avs_waitrequest) |=> !avs_waitrequest)
        else $error("request not answered in one cycle");

    // Registers come up cleared after reset
    chk_reset_values: assert property (@(posedge clk) disable iff (!nrst)
        after_rst |-> (ff_write_protect_lo == 16'h0000 && ff_source_select_lo == 16'h0000
                       && ff_out == '0))
        else $error("registers not cleared after reset");

    // Unused select bits stay zero in the readback
    chk_unused_zero: assert property (@(posedge clk) disable iff (!nrst)
        (avs_read && avs_waitrequest && avs_address == IDX_SRC_SEL_LO)
        |=> avs_readdata[15:13] == 3'b000)
        else $error("unused select bits read nonzero");

    // Locked flip-flops hold through a data write unless their source acts
    chk_lock_holds: assert property (@(posedge clk) disable iff (!nrst)
        wr_data |=> (((ff_out[15:0] ^ $past(ff_out[15:0])) & $past(ff_write_protect_lo)
                      & ~$past(sel_evt[15:0])) == 16'h0000))
        else $error("locked flip-flop changed on data write");

    // Unlocked written bits take the written value
    chk_write_forces: assert property (@(posedge clk) disable iff (!nrst)
        wr_data |=> (((ff_out[15:0] ^ $past(avs_writedata[15:0])) & $past(wmask16)
                      & ~$past(ff_write_protect_lo)) == 16'h0000))
        else $error("permitted data write did not force output");

    // Without a write, only selected events toggle the outputs
    chk_event_toggle: assert property (@(posedge clk) disable iff (!nrst)
        !wr_data |=> (ff_out ^ $past(ff_out)) == $past(sel_evt))
        else $error("output change does not match selected source");

    // Flip-flop 13 on bus line 3 when its selector is set
    chk_sel_thirteen: assert property (@(posedge clk) disable iff (!nrst)
        sel_evt[13] == (ff_source_select_lo[POS_SEL_THIRTEEN] ? evt_bus[3] : ch_evt[13]))
        else $error("wrong source for flip-flop 13");

    // Flip-flop 10 code 11 picks bus line 1
    chk_sel_ten: assert property (@(posedge clk) disable iff (!nrst)
        (ff_source_select_lo[7:6] == 2'b11) |-> sel_evt[10] == evt_bus[1])
        else $error("wrong source for flip-flop 10");

    // Flip-flop 8 code 11 picks bus line 2
    chk_sel_eight: assert property (@(posedge clk) disable iff (!nrst)
        (ff_source_select_lo[3:2] == 2'b11) |-> sel_evt[8] == evt_bus[2])
        else $error("wrong source for flip-flop 8");

    // Flip-flop 6 on bus line 1 when set
    chk_sel_six: assert property (@(posedge clk) disable iff (!nrst)
        ff_source_select_lo[0] |-> sel_evt[6] == evt_bus[1])
        else $error("wrong source for flip-flop 6");

    // Flip-flop 19 code 10 picks bus line 0
    chk_sel_nineteen: assert property (@(posedge clk) disable iff (!nrst)
        (ff_source_select_hi[7:6] == 2'b10) |-> sel_evt[19] == evt_bus[0])
        else $error("wrong source for flip-flop 19");

    // Flip-flop 16 code 11 picks bus line 3
    chk_sel_sixteen: assert property (@(posedge clk) disable iff (!nrst)
        (ff_source_select_hi[1:0] == 2'b11) |-> sel_evt[16] == evt_bus[3])
        else $error("wrong source for flip-flop 16");

endmodule : tfp_ff_ctrl

// >>> src/tfp_pkg.sv
// Constants shared by the timer output flip-flop source and protect block
package tfp_pkg;

    // Register indices; the Avalon byte address is four times the index
    localparam logic [31:0] OFS_SRC_SEL_LO   = 32'h0080_0220;
    localparam logic [31:0] OFS_SRC_SEL_HI   = 32'h0080_0223;
    localparam logic [31:0] OFS_WR_LOCK_LO   = 32'h0080_0224;
    localparam logic [31:0] OFS_OUT_DATA     = 32'h0080_0226;
    localparam int          ADDR_W           = 12;
    localparam logic [11:0] IDX_SRC_SEL_LO   = OFS_SRC_SEL_LO[11:0];
    localparam logic [11:0] IDX_SRC_SEL_HI   = OFS_SRC_SEL_HI[11:0];
    localparam logic [11:0] IDX_WR_LOCK_LO   = OFS_WR_LOCK_LO[11:0];
    localparam logic [11:0] IDX_OUT_DATA     = OFS_OUT_DATA[11:0];

    // Values after reset
    localparam logic [15:0] RST_SRC_SEL_LO   = 16'h0000;
    localparam logic [7:0]  RST_SRC_SEL_HI   = 8'h00;
    localparam logic [15:0] RST_WR_LOCK_LO   = 16'h0000;
    localparam logic        RST_FF_OUT       = 1'b0;

    // Writable bits of the low select register (top three bits unused)
    localparam logic [15:0] SRC_SEL_LO_WMASK = 16'h1fff;

    // Field positions, counted from the halfword LSB (document bit 15)
    localparam int POS_SEL_FIFTEEN   = 12;
    localparam int POS_SEL_FOURTEEN  = 11;
    localparam int POS_SEL_THIRTEEN  = 10;
    localparam int POS_SEL_TWELVE    = 9;
    localparam int POS_SEL_ELEVEN    = 8;
    localparam int POS_SEL_TEN       = 6;
    localparam int POS_SEL_NINE      = 4;
    localparam int POS_SEL_EIGHT     = 2;
    localparam int POS_SEL_SEVEN     = 1;
    localparam int POS_SEL_SIX       = 0;
    localparam int POS_SEL_NINETEEN  = 6;
    localparam int POS_SEL_EIGHTEEN  = 4;
    localparam int POS_SEL_SEVENTEEN = 2;
    localparam int POS_SEL_SIXTEEN   = 0;

    // Block dimensions
    localparam int NUM_FF   = 20;
    localparam int NUM_LOCK = 16;
    localparam int EVT_W    = 4;

endpackage : tfp_pkg

// >>> testbench/tb_tfp_ff_ctrl.sv
// Self-checking bench for the flip-flop source select and write protect block
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_tfp_ff_ctrl;
    import tfp_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, pen = 1'b0;
    logic [11:0] avs_address = 12'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_val, r;
    logic [3:0]  avs_byteenable = 4'h3, evt_bus;
    logic        avs_waitrequest;
    logic [19:0] ch_evt, ff_out, m_ff = 20'h0, m_nx;
    logic [15:0] m_lo = 16'h0, m_lock = 16'h0, lk;
    logic [7:0]  m_hi = 8'h0;
    int          miscompares = 0, total_checks = 0;
    int          bmap[5] = '{1, 2, 3, 0, 0};

    always #5 clk = ~clk;

    tfp_ff_ctrl #(.N_FF(20)) tfp_ff_ctrl_i (.clk(clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ch_evt(ch_evt), .evt_bus(evt_bus), .ff_out(ff_out));
    tfp_src_model tfp_src_model_i (.clk(clk), .nrst(nrst), .en(pen), .ch_evt(ch_evt),
        .evt_bus(evt_bus));

    // Event that the model expects to reach flip-flop k under the current selection
    function automatic logic src_of(input int k);
        logic [1:0] s;
        case (k)
            11, 12, 13, 14, 15:
                return m_lo[k - 3] ? evt_bus[bmap[k - 11]] : ch_evt[k];
            10: return m_lo[7] ? evt_bus[m_lo[6]] : ch_evt[10];
            9: return m_lo[5] ? evt_bus[m_lo[4]] : ch_evt[9];
            8: return m_lo[3:2] == 2'h0 ? ch_evt[8] : evt_bus[m_lo[3:2] - 2'h1];
            7: return m_lo[1] ? evt_bus[0] : ch_evt[7];
            6: return m_lo[0] ? evt_bus[1] : ch_evt[6];
            16: return m_hi[1:0] == 2'h0 ? ch_evt[16] :
                (m_hi[1:0] == 2'h3 ? evt_bus[3] : evt_bus[m_hi[1:0] - 2'h1]);
            17, 18, 19: begin
                s = m_hi[2 * (k - 16) +: 2];
                return s[1] ? evt_bus[s[0]] : ch_evt[k];
            end
            default: return ch_evt[k];
        endcase
    endfunction : src_of

    // Reference model; selection updates after the flip-flops so a new source acts next cycle
    always @(posedge clk) begin
        if (!nrst) begin
            m_ff = 20'h0;
            m_lo = 16'h0;
            m_hi = 8'h0;
            m_lock = 16'h0;
        end else begin
            for (int k = 0; k < 20; k++) begin
                m_nx[k] = m_ff[k] ^ src_of(k);
                if (avs_write && !avs_waitrequest && avs_address == IDX_OUT_DATA && k < 16
                    && avs_byteenable[k / 8] && !m_lock[k])
                    m_nx[k] = avs_writedata[k];
            end
            m_ff = m_nx;
            for (int b = 0; b < 2; b++) begin
                if (avs_write && !avs_waitrequest && avs_byteenable[b]) begin
                    if (avs_address == IDX_SRC_SEL_LO)
                        m_lo[8 * b +: 8] = avs_writedata[8 * b +: 8] & SRC_SEL_LO_WMASK[8 * b +: 8];
                    if (avs_address == IDX_WR_LOCK_LO)
                        m_lock[8 * b +: 8] = avs_writedata[8 * b +: 8];
                    if (avs_address == IDX_SRC_SEL_HI && b == 0)
                        m_hi = avs_writedata[7:0];
                end
            end
        end
    end

    // Outputs are compared mid-cycle, well clear of the launching edge
    always @(negedge clk) if (nrst) `CHK(ff_out, m_ff)

    // One Avalon transfer; an idle edge first so no request is raised twice in one step
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        // Waits for the answer however long it takes; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd_val = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'h3);
        `CHK(rd_val, e)
    endtask : rchk

    task automatic end_sim;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    // Watchdog well beyond the few thousand cycles the sequence needs
    initial begin
        repeat (50000) @(posedge clk);
        miscompares++;
        end_sim;
    end

    initial begin
        void'($urandom(32'ha4986366));
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rchk(IDX_SRC_SEL_LO, 32'h0);
        rchk(IDX_WR_LOCK_LO, 32'h0);
        rchk(IDX_SRC_SEL_HI, 32'h0);
        rchk(12'h3ff, 32'h0);
        bus(1'b1, IDX_SRC_SEL_LO, 32'hffff, 4'h3);
        bus(1'b1, 12'h3ff, 32'h0, 4'h3);
        rchk(IDX_SRC_SEL_LO, 32'h1fff);
        // Random selections and forced writes while sources pulse
        pen <= 1'b1;
        repeat (60) begin
            r = $urandom;
            bus(1'b1, IDX_SRC_SEL_LO, r & 32'hffff, 4'h3);
            bus(1'b1, IDX_SRC_SEL_HI, r >> 24, 4'h1);
            bus(1'b1, IDX_WR_LOCK_LO, $urandom & 32'hffff, 4'h3);
            bus(1'b1, IDX_OUT_DATA, $urandom & 32'hffff, 4'h3);
            rchk(IDX_SRC_SEL_HI, {24'h0, m_hi});
            repeat ($urandom_range(20)) @(posedge clk);
        end
        pen <= 1'b0;
        // Quiet sources: lock patterns from none to all, then data writes and readback
        for (int i = 0; i < 8; i++) begin
            lk = (i == 0) ? 16'h0 : (i == 1) ? 16'hffff : 16'($urandom);
            bus(1'b1, IDX_WR_LOCK_LO, {16'h0, lk}, 4'h3);
            rchk(IDX_WR_LOCK_LO, {16'h0, lk});
            bus(1'b1, IDX_OUT_DATA, $urandom & 32'hffff, 4'h3);
            // Expected value taken after the read, once the model has seen the write edge
            bus(1'b0, IDX_OUT_DATA, 32'h0, 4'h3);
            `CHK(rd_val, {16'h0, m_ff[15:0]})
        end
        // Reset in mid-run clears every register again
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rchk(IDX_SRC_SEL_LO, 32'h0);
        rchk(IDX_WR_LOCK_LO, 32'h0);
        end_sim;
    end
endmodule : tb_tfp_ff_ctrl

// >>> testbench/tfp_src_model.sv
// Stand-in for the timer channels and the output event bus
`timescale 1ns/1ns
module tfp_src_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        en,
    output logic      [19:0] ch_evt,
    output logic      [3:0]  evt_bus
);
    // Sparse one-cycle pulses; two draws ANDed keep most cycles quiet so toggles stay visible
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ch_evt  <= 20'h0;
            evt_bus <= 4'h0;
        end else if (en) begin
            ch_evt  <= 20'($urandom & $urandom);
            evt_bus <= 4'($urandom & $urandom);
        end else begin
            ch_evt  <= 20'h0;
            evt_bus <= 4'h0;
        end
    end
endmodule : tfp_src_model
